// ---- shared/ext_bus_pkg.sv ----
// Function
// - One shared 16-bit two-way data bus
// - Data bus floats unless writing, and floats in reset
// - Output disable floats every bus output
// - Drive 16-bit address of the access
// - Program select low only for program access
// - Data select low only for data access
// - I/O select low only for I/O access
// - Ready low stretches external access one more cycle
// - Direction high, low only during writes
// - Strobe low for each external bus cycle
// - Read select active on every external read
// - Internal I/O accesses still shown at pins
// - Write enable active on every external write
// - Disable: test reset 0, emulator 1, pin 0
`default_nettype none
package ext_bus_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;

    typedef enum logic [1:0] {
        SPACE_PROG = 2'h0,
        SPACE_DATA = 2'h1,
        SPACE_IO = 2'h2
    } space_e;

    // Core-side request
    typedef struct packed {
        logic valid;
        logic write;
        logic internal_io;
        space_e space;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_s;

    // Pin-side control outputs, all active low except direction
    typedef struct packed {
        logic program_space_select_n;
        logic data_space_select_n;
        logic io_space_select_n;
        logic bus_cycle_strobe_n;
        logic read_not_write;
        logic read_select_n;
        logic write_enable_n;
    } bus_ctl_s;

    localparam bus_ctl_s CTL_IDLE = 7'h7f;

endpackage
`default_nettype wire

// ---- logic/output_disable_detect.sv ----
`timescale 1ns/1ps
`default_nettype none
module output_disable_detect (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic test_reset_i,
    input wire logic emulator_pin_zero_i,
    input wire logic emu_off_n_i,
    output logic off_o
);
    // Registered so the float decision lines up with registered outputs
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            off_o <= 1'b0;
        end else if (clk_en_i) begin
            off_o <= !test_reset_i && emulator_pin_zero_i && !emu_off_n_i;
        end
    end
endmodule
`default_nettype wire

// ---- logic/external_memory_bus_interface.sv ----
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_interface (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire ext_bus_pkg::bus_req_s req_i,
    output logic req_ready_o,
    output logic done_o,
    output logic [ext_bus_pkg::DATA_W-1:0] rdata_o,
    input wire logic test_reset_i,
    input wire logic emulator_pin_zero_i,
    input wire logic emu_off_n_i,
    input wire logic ready_i,
    output logic [ext_bus_pkg::ADDR_W-1:0] addr_o,
    output logic addr_oe_o,
    input wire logic [ext_bus_pkg::DATA_W-1:0] data_i,
    output logic [ext_bus_pkg::DATA_W-1:0] data_o,
    output logic data_oe_o,
    output ext_bus_pkg::bus_ctl_s ctl_o,
    output logic ctl_oe_o
);
    import ext_bus_pkg::*;

    // ************************************************************
    // Output disable
    // ************************************************************
    logic off;

    output_disable_detect u_off (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .test_reset_i(test_reset_i),
        .emulator_pin_zero_i(emulator_pin_zero_i),
        .emu_off_n_i(emu_off_n_i),
        .off_o(off)
    );

    // ************************************************************
    // Cycle sequencer
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACCESS = 2'b10
    } state_e;

    state_e state_q;
    logic cur_write_q;
    logic cur_int_q;

    wire logic take = clk_en_i && state_q == ST_IDLE && req_i.valid;
    wire logic finish = clk_en_i && state_q == ST_ACCESS && (ready_i || cur_int_q);

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
        end else if (clk_en_i) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (req_i.valid) begin
                        state_q <= ST_ACCESS;
                    end
                end
                ST_ACCESS: begin
                    // Ready low keeps an external access one more cycle, then rechecks
                    if (ready_i || cur_int_q) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cur_write_q <= 1'b0;
            cur_int_q <= 1'b0;
            addr_o <= '0;
            data_o <= '0;
        end else if (take) begin
            cur_write_q <= req_i.write;
            cur_int_q <= req_i.internal_io;
            addr_o <= req_i.addr;
            data_o <= req_i.wdata;
        end
    end

    // ************************************************************
    // Pin controls
    // ************************************************************
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ctl_o <= CTL_IDLE;
        end else if (take) begin
            // Internal I/O registers still show select, direction and data
            ctl_o <= CTL_IDLE;
            ctl_o.program_space_select_n <= !(req_i.space == SPACE_PROG
                && !req_i.internal_io);
            ctl_o.data_space_select_n <= !(req_i.space == SPACE_DATA && !req_i.internal_io);
            ctl_o.io_space_select_n <= !(req_i.space == SPACE_IO);
            ctl_o.read_not_write <= !req_i.write;
            ctl_o.bus_cycle_strobe_n <= req_i.internal_io;
            ctl_o.read_select_n <= req_i.write || req_i.internal_io;
            ctl_o.write_enable_n <= !req_i.write || req_i.internal_io;
        end else if (finish) begin
            ctl_o <= CTL_IDLE;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            data_oe_o <= 1'b0;
        end else if (clk_en_i) begin
            data_oe_o <= !off && ((take && req_i.write) || (state_q == ST_ACCESS && !finish
                && cur_write_q));
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            addr_oe_o <= 1'b0;
            ctl_oe_o <= 1'b0;
        end else if (clk_en_i) begin
            addr_oe_o <= !off;
            ctl_oe_o <= !off;
        end
    end

    // ************************************************************
    // Core answer
    // ************************************************************
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            done_o <= 1'b0;
            rdata_o <= '0;
            req_ready_o <= 1'b0;
        end else if (clk_en_i) begin
            done_o <= finish;
            req_ready_o <= state_q == ST_IDLE && !req_i.valid || finish;
            if (finish && !cur_write_q) begin
                rdata_o <= data_i;
            end
        end else begin
            done_o <= 1'b0;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    one_select_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        $countones({ctl_o.program_space_select_n, ctl_o.data_space_select_n,
        ctl_o.io_space_select_n}) >= 2)
        else $error("more than one space select active");

    float_off_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        clk_en_i && off |=> !addr_oe_o && !ctl_oe_o && !data_oe_o)
        else $error("outputs driven during output disable");

    data_float_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        data_oe_o |-> !ctl_o.read_not_write)
        else $error("data bus driven outside a write");

    ready_wait_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        clk_en_i && state_q == ST_ACCESS && !ready_i && !cur_int_q |=> state_q == ST_ACCESS)
        else $error("access ended with ready low");

    single_cycle_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        take ##1 (clk_en_i && ready_i) |=> done_o && ctl_o == CTL_IDLE)
        else $error("access not done in one cycle");

    strobe_cycle_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        !ctl_o.bus_cycle_strobe_n |-> state_q == ST_ACCESS)
        else $error("strobe low outside bus cycle");

    read_select_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        take && !req_i.write && !req_i.internal_io |=> !ctl_o.read_select_n)
        else $error("read select missing on read");

    write_enable_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        !ctl_o.write_enable_n |-> !ctl_o.read_not_write && ctl_o.read_select_n)
        else $error("write enable outside write");

    io_visible_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        take && req_i.internal_io && req_i.space == SPACE_IO |=> !ctl_o.io_space_select_n)
        else $error("internal io access not visible");

endmodule
`default_nettype wire

// ---- tb/ext_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ***
// Far-side memory: stalls on request, bus floats to inverse when idle
// ***
module ext_mem_model (
    input wire logic mclk_i,
    input wire ext_bus_pkg::bus_ctl_s ctl_i,
    input wire logic ctl_oe_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [3:0] waits_i,
    output logic ready_o,
    output logic [15:0] data_o,
    output logic [15:0] wr_seen_o
);
    import ext_bus_pkg::*;
    logic [3:0] cnt_q = 4'h0;
    logic [15:0] last_q = 16'h0;
    logic rd_on;
    always @(posedge mclk_i) begin
        cnt_q <= ctl_i.bus_cycle_strobe_n ? waits_i : cnt_q - {3'h0, |cnt_q};
        if (!ctl_i.write_enable_n) wr_seen_o <= wdata_i;
        if (rd_on) last_q <= data_o;
    end
    assign ready_o = (cnt_q == 4'h0);
    assign rd_on = ctl_oe_i && !ctl_i.read_select_n;
    // Released bus shows the inverse so a stale sample cannot pass
    assign data_o = rd_on ? ({addr_i[7:0], addr_i[15:8]} ^ 16'h3c5a) : ~last_q;
endmodule
`default_nettype wire

// ---- tb/external_memory_bus_interface_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_interface_tb;
    import ext_bus_pkg::*;
    logic mclk_i = 0, reset_i = 1, clk_en_i = 1, test_reset = 1, emu_zero = 0, emu_off_n = 1;
    logic ready, done, addr_oe, data_oe, ctl_oe, req_rdy;
    logic [15:0] rdata, addr, wdata, rd_bus, wr_seen;
    logic [31:0] seed = 32'he27f15b8;
    logic [3:0] waits = 4'h0;
    bus_req_s req = '0;
    bus_ctl_s ctl;
    int errors = 0, samples_checked = 0;
    always #12.5 mclk_i = ~mclk_i;
    external_memory_bus_interface i_external_memory_bus_interface (.mclk_i(mclk_i),
        .reset_i(reset_i), .clk_en_i(clk_en_i), .req_i(req), .req_ready_o(req_rdy), .done_o(done),
        .rdata_o(rdata), .test_reset_i(test_reset), .emulator_pin_zero_i(emu_zero),
        .emu_off_n_i(emu_off_n), .ready_i(ready), .addr_o(addr), .addr_oe_o(addr_oe),
        .data_i(rd_bus), .data_o(wdata), .data_oe_o(data_oe), .ctl_o(ctl), .ctl_oe_o(ctl_oe));
    ext_mem_model i_ext_mem_model (.mclk_i(mclk_i), .ctl_i(ctl), .ctl_oe_i(ctl_oe),
        .addr_i(addr), .wdata_i(wdata), .waits_i(waits), .ready_o(ready), .data_o(rd_bus),
        .wr_seen_o(wr_seen));
    // ***
    // Helpers
    // ***
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [2:0] sel_exp(input space_e s);
        return 3'h7 & ~(3'h4 >> s);
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask
    task automatic summarize();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Called at a falling edge with the interface idle
    task automatic access(input logic w, ii, input space_e s, input logic [15:0] a, d);
        int n;
        n = 0;
        req <= '{1'b1, w, ii, s, a, d};
        @(negedge mclk_i);
        req.valid <= 1'b0;
        check(ctl, {sel_exp(s), ii, !w, w | ii, !w | ii}, "ctl");
        check({data_oe, addr_oe, ctl_oe, req_rdy}, {w, 3'b110}, "enables");
        check(addr, a, "address");
        if (w) check(wdata, d, "write data");
        while (done !== 1'b1 && n < 20) begin
            @(negedge mclk_i);
            n++;
        end
        check(16'(n), ii ? 16'h1 : 16'h1 + waits, "latency");
        if (n == 20) summarize();
        check({ctl, req_rdy}, {CTL_IDLE, 1'b1}, "idle control");
        if (!w && !ii) check(rdata, {a[7:0], a[15:8]} ^ 16'h3c5a, "read data");
        if (w && !ii) check(wr_seen, d, "latched write");
    endtask
    // ***
    // Sequence
    // ***
    initial begin
        logic [31:0] r;
        repeat (16) @(negedge mclk_i);
        check({ctl, addr_oe, data_oe, ctl_oe, done}, {CTL_IDLE, 4'h0}, "reset floats");
        reset_i <= 1'b0;
        @(negedge mclk_i);
        for (int k = 0; k < 3; k++) access(1'b1, 1'b0, space_e'(k), 16'hffff, 16'h8001);
        for (int k = 0; k < 3; k++) access(1'b0, 1'b0, space_e'(k), 16'h0000, 16'h0);
        access(1'b0, 1'b1, SPACE_IO, 16'h00ff, 16'h0);
        access(1'b1, 1'b1, SPACE_IO, 16'h00fe, 16'ha5c3);
        repeat (40) begin
            r = rnd();
            waits <= 4'(r[19:16] % 5);
            access(r[20], 1'b0, space_e'(r[22:21] % 3), r[15:0], r[31:16]);
        end
        // Reset in mid-access must drop the cycle and float the data bus
        waits <= 4'h3;
        req <= '{1'b1, 1'b1, 1'b0, SPACE_PROG, 16'h0f0f, 16'hbeef};
        @(negedge mclk_i);
        req.valid <= 1'b0;
        reset_i <= 1'b1;
        @(negedge mclk_i);
        check({ctl, addr_oe, data_oe, ctl_oe, done}, {CTL_IDLE, 4'h0}, "mid reset");
        reset_i <= 1'b0;
        @(negedge mclk_i);
        check({ctl, addr_oe, ctl_oe, data_oe}, {CTL_IDLE, 3'b110}, "after reset");
        // A low enable freezes the access; it finishes once let go
        waits <= 4'h0;
        req <= '{1'b1, 1'b0, 1'b0, SPACE_DATA, 16'h1234, 16'h0};
        @(negedge mclk_i);
        req.valid <= 1'b0;
        clk_en_i <= 1'b0;
        repeat (4) @(negedge mclk_i);
        check({done, ctl}, {1'b0, sel_exp(SPACE_DATA), 4'h5}, "frozen");
        clk_en_i <= 1'b1;
        @(negedge mclk_i);
        check({done, ctl}, {1'b1, CTL_IDLE}, "thawed");
        check(rdata, 16'h3412 ^ 16'h3c5a, "thawed read");
        // Only the full 0,1,0 pattern may float the outputs
        for (int k = 0; k < 4; k++) begin
            {test_reset, emu_zero, emu_off_n} <= 3'h2 ^ (3'h1 << k);
            repeat (3) @(negedge mclk_i);
            check({addr_oe, ctl_oe, data_oe}, {{2{k < 3}}, 1'b0}, "disable");
        end
        {test_reset, emu_zero, emu_off_n} <= 3'h5;
        repeat (3) @(negedge mclk_i);
        summarize();
    end
endmodule
`default_nettype wire
